// file: rtl/wdt_pkg.sv
`default_nettype none
package wdt_pkg;
   // register byte offsets
   localparam logic [3:0] OFS_CFG   = 4'h0;
   localparam logic [3:0] OFS_RESET_CONTROL_REGISTER  = 4'h4;
   localparam logic [3:0] OFS_COUNT = 4'h8;
   // reset_control_register bit positions
   localparam int RC_IDLE  = 2;
   localparam int RC_SLEEP = 3;
   localparam int RC_WATCHDOG_TIMEOUT_FLAG  = 4;
   localparam int RC_SWEN  = 5;
   localparam int CFG_W    = 13;
   // prescaler terminal counts and shifts
   localparam logic [6:0] PRE_SHORT_MAX = 7'h1f;
   localparam logic [6:0] PRE_LONG_MAX  = 7'h7f;
   localparam int PRE_SHORT_SH = 5;
   localparam int PRE_LONG_SH  = 7;

   typedef enum logic [1:0] {
      en_off  = 2'b00,
      en_rsvd = 2'b01,
      en_soft = 2'b10,
      en_on   = 2'b11
   } en_cfg_e;

   typedef enum logic [1:0] {
      cs_sys  = 2'b00,
      cs_secondary_osc = 2'b01,
      cs_frc  = 2'b10,
      cs_low_power_rc_osc = 2'b11
   } clk_sel_e;

   typedef enum logic [1:0] {
      pw_run   = 2'b00,
      pw_sleep = 2'b01,
      pw_idle  = 2'b10
   } pwr_e;

   typedef struct packed {
      logic [1:0] window_width_select;
      logic       watchdog_clock_mux_enable;
      clk_sel_e   watchdog_clock_select;
      en_cfg_e    watchdog_enable_config;
      logic       window_disable_config;
      logic       prescale_width_select;
      logic [3:0] postscale_ratio_select;
   } cfg_s;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [3:0]  addr;
      logic [31:0] wdata;
   } bus_req_s;

   typedef struct packed {
      logic watchdog_clear_instruction;
      logic power_save_instruction;
      logic power_save_idle;
      logic clock_switch_done;
      logic device_reset;
      logic other_wake;
      logic low_power_rc_osc_is_sysclk;
   } ev_s;

   typedef struct packed {
      logic low_power_rc_osc;
      logic fast_rc_osc;
      logic secondary_osc;
   } osc_s;

   typedef struct packed {
      cfg_s        cfg;
      logic [6:0]  pre;
      logic [14:0] post;
      osc_s        osc_prev;
      osc_s        osc_en;
      pwr_e        pwr;
      logic        swen;
      logic        watchdog_timeout_flag;
      logic        sleep_f;
      logic        idle_f;
      logic        wdt_reset;
      logic        wake;
      logic        running;
      logic [31:0] rdata;
   } state_s;

   localparam cfg_s CFG_RST = '{
      window_width_select:       2'h0,
      watchdog_clock_mux_enable: 1'b0,
      watchdog_clock_select:     cs_low_power_rc_osc,
      watchdog_enable_config:    en_soft,
      window_disable_config:     1'b1,
      prescale_width_select:     1'b1,
      postscale_ratio_select:    4'hf
   };

   localparam state_s STATE_RST = '{
      cfg: CFG_RST, pre: 7'h0, post: 15'h0, osc_prev: 3'h0, osc_en: 3'h0,
      pwr: pw_run, swen: 1'b0, watchdog_timeout_flag: 1'b0, sleep_f: 1'b0, idle_f: 1'b0,
      wdt_reset: 1'b0, wake: 1'b0, running: 1'b0, rdata: 32'h0
   };
endpackage : wdt_pkg
`default_nettype wire

// file: rtl/windowed_watchdog_timer.sv
// Notes on behaviour
// - prescaler divides by 32 or 128
// - base period about 1 ms or 4 ms
// - postscaler ratios 1:1 to 1:32768, sixteen steps
// - resets, clock switch, power save, clear restart
// - counting continues during sleep and idle
// - time-out in power save wakes, no reset
// - time-out flag sticks until software clears it
// - windowed clear works only in final window
// - early windowed clear causes watchdog reset
// - window active only when disable bit zero
// - enable field 11 runs always
// - enable field 10 follows software enable bit
// - enable field 00 never runs
// - device reset clears software enable bit
// - clock select picks source when mux enabled
// - mux disabled uses low-power rc always
// - fast rc only windowed, awake, low-power rc not sysclk
// - enabling watchdog enables its clock source
`default_nettype none
module windowed_watchdog_timer
   import wdt_pkg::*;
(
   input  wire logic     clk,
   input  wire logic     rst,
   input  wire bus_req_s bus,
   output logic [31:0]   rdata,
   input  wire ev_s      ev,
   input  wire osc_s     osc_in,
   output osc_s          osc_enable,
   output logic          wdt_reset,
   output logic          wake,
   output logic          running
);

   state_s s_r;
   state_s s_nxt;

   // terminal count of prescaler
   function automatic logic [6:0] pre_max_f(input cfg_s c);
      pre_max_f = c.prescale_width_select ? PRE_LONG_MAX : PRE_SHORT_MAX;
   endfunction : pre_max_f

   // whole period in source ticks
   function automatic logic [22:0] period_f(input cfg_s c);
      logic [22:0] r;
      r = 23'h1 << c.postscale_ratio_select;
      period_f = c.prescale_width_select ? (r << PRE_LONG_SH) : (r << PRE_SHORT_SH);
   endfunction : period_f

   // elapsed ticks from both counters
   function automatic logic [22:0] elapsed_f(input logic [6:0] pre,
                                            input logic [14:0] post,
                                            input cfg_s c);
      logic [22:0] p;
      p = {8'h0, post};
      elapsed_f = (c.prescale_width_select ? (p << PRE_LONG_SH) : (p << PRE_SHORT_SH))
                  | {16'h0, pre};
   endfunction : elapsed_f

   // tick count at which the window opens
   function automatic logic [22:0] win_start_f(input logic [22:0] p,
                                              input logic [1:0] w);
      case (w)
         2'b00: begin
            win_start_f = p - (p >> 2);
         end
         2'b01: begin
            win_start_f = p - (p >> 2) - (p >> 3);
         end
         2'b10: begin
            win_start_f = p >> 1;
         end
         default: begin
            win_start_f = p >> 2;
         end
      endcase
   endfunction : win_start_f

   // run decision from enable field
   function automatic logic enabled_f(input en_cfg_e e, input logic swen);
      case (e)
         en_on: begin
            enabled_f = 1'b1;
         end
         en_soft: begin
            enabled_f = swen;
         end
         default: begin
            enabled_f = 1'b0;
         end
      endcase
   endfunction : enabled_f

   // selected source, all zero for system clock outside power save
   function automatic osc_s src_f(input cfg_s c, input logic save,
                                  input logic low_power_rc_osc_sys);
      osc_s m;
      m = '0;
      m.low_power_rc_osc = 1'b1;
      if (c.watchdog_clock_mux_enable) begin
         case (c.watchdog_clock_select)
            cs_secondary_osc: begin
               m = '0;
               m.secondary_osc = 1'b1;
            end
            cs_frc: begin
               if (!c.window_disable_config && !low_power_rc_osc_sys && !save) begin
                  m = '0;
                  m.fast_rc_osc = 1'b1;
               end
            end
            cs_sys: begin
               if (!save) begin
                  m = '0;
               end
            end
            default: begin
               m.low_power_rc_osc = 1'b1;
            end
         endcase
      end
      src_f = m;
   endfunction : src_f

   always_comb begin
      logic [22:0] per;
      logic [22:0] el;
      logic [22:0] wst;
      osc_s        src;
      logic        save;
      logic        run;
      logic        tick;
      logic        to_evt;
      logic        early;
      logic        ok_clr;
      logic        enter;
      logic        leave;
      logic        clr;
      per    = '0;
      el     = '0;
      wst    = '0;
      src    = '0;
      save   = 1'b0;
      run    = 1'b0;
      tick   = 1'b0;
      to_evt = 1'b0;
      early  = 1'b0;
      ok_clr = 1'b0;
      enter  = 1'b0;
      leave  = 1'b0;
      clr    = 1'b0;

      s_nxt           = s_r;
      s_nxt.wdt_reset = 1'b0;
      s_nxt.wake      = 1'b0;
      s_nxt.rdata     = 32'h0;
      s_nxt.osc_prev  = osc_in;

      save = (s_r.pwr != pw_run);
      run  = enabled_f(s_r.cfg.watchdog_enable_config, s_r.swen);
      src  = src_f(s_r.cfg, save, ev.low_power_rc_osc_is_sysclk);
      if (src == osc_s'(3'h0)) begin
         tick = run;
      end else begin
         tick = run && ((src & osc_in & ~s_r.osc_prev) != osc_s'(3'h0));
      end
      per = period_f(s_r.cfg);
      el  = elapsed_f(s_r.pre, s_r.post, s_r.cfg);
      wst = win_start_f(per, s_r.cfg.window_width_select);

      to_evt = tick && (el == per - 23'h1);
      early  = run && !save && !s_r.cfg.window_disable_config
               && ev.watchdog_clear_instruction && (el < wst);
      ok_clr = ev.watchdog_clear_instruction && !save && !early;
      enter  = ev.power_save_instruction && !save && !ev.device_reset;
      leave  = save && (ev.other_wake || to_evt);

      clr = ev.device_reset || ev.clock_switch_done || ok_clr || early
            || to_evt || enter || leave || !run;

      if (clr) begin
         s_nxt.pre  = 7'h0;
         s_nxt.post = 15'h0;
      end else if (tick) begin
         if (s_r.pre == pre_max_f(s_r.cfg)) begin
            s_nxt.pre  = 7'h0;
            s_nxt.post = s_r.post + 15'h1;
         end else begin
            s_nxt.pre = s_r.pre + 7'h1;
         end
      end

      // register writes
      if (bus.wr) begin
         case (bus.addr)
            OFS_CFG: begin
               s_nxt.cfg = cfg_s'(bus.wdata[CFG_W-1:0]);
            end
            OFS_RESET_CONTROL_REGISTER: begin
               s_nxt.swen    = bus.wdata[RC_SWEN];
               s_nxt.watchdog_timeout_flag    = bus.wdata[RC_WATCHDOG_TIMEOUT_FLAG];
               s_nxt.sleep_f = bus.wdata[RC_SLEEP];
               s_nxt.idle_f  = bus.wdata[RC_IDLE];
            end
            default: begin
               s_nxt.swen = s_r.swen;
            end
         endcase
      end

      // power save entry
      if (enter) begin
         if (ev.power_save_idle) begin
            s_nxt.pwr    = pw_idle;
            s_nxt.idle_f = 1'b1;
         end else begin
            s_nxt.pwr     = pw_sleep;
            s_nxt.sleep_f = 1'b1;
         end
      end

      if (leave) begin
         s_nxt.pwr  = pw_run;
         s_nxt.wake = to_evt;
      end

      if ((to_evt && !save) || early) begin
         s_nxt.wdt_reset = 1'b1;
      end

      if (to_evt || early) begin
         s_nxt.watchdog_timeout_flag = 1'b1;
      end

      if (ev.device_reset) begin
         s_nxt.swen = 1'b0;
         s_nxt.pwr  = pw_run;
      end

      s_nxt.osc_en  = run ? src : osc_s'(3'h0);
      s_nxt.running = run;

      // register reads
      if (bus.rd) begin
         case (bus.addr)
            OFS_CFG: begin
               s_nxt.rdata = {19'h0, s_r.cfg};
            end
            OFS_RESET_CONTROL_REGISTER: begin
               s_nxt.rdata = {26'h0, s_r.swen, s_r.watchdog_timeout_flag, s_r.sleep_f, s_r.idle_f, 2'h0};
            end
            OFS_COUNT: begin
               s_nxt.rdata = {10'h0, s_r.post, s_r.pre};
            end
            default: begin
               s_nxt.rdata = 32'h0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_r <= STATE_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rdata      = s_r.rdata;
   assign osc_enable = s_r.osc_en;
   assign wdt_reset  = s_r.wdt_reset;
   assign wake       = s_r.wake;
   assign running    = s_r.running;

endmodule : windowed_watchdog_timer
`default_nettype wire

// file: bench/windowed_watchdog_timer_props.sv
`default_nettype none
module windowed_watchdog_timer_props
   import wdt_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst,
   input wire bus_req_s    bus,
   input wire logic [31:0] rdata,
   input wire ev_s         ev,
   input wire osc_s        osc_in,
   input wire osc_s        osc_enable,
   input wire logic        wdt_reset,
   input wire logic        wake,
   input wire logic        running
);
   logic [1:0] en_r;
   logic       mx_r;
   logic       fl_r;
   logic       fl;
   assign fl = fl_r | wdt_reset | wake;
   // enable field, mux bit and flag shadow
   always_ff @(posedge clk) begin
      if (rst) begin
         en_r <= 2'b10;
         mx_r <= 1'b0;
         fl_r <= 1'b0;
      end else begin
         if (bus.wr && bus.addr == OFS_CFG) begin
            en_r <= bus.wdata[7:6];
            mx_r <= bus.wdata[10];
         end
         if (wdt_reset || wake) begin
            fl_r <= 1'b1;
         end else if (bus.wr && bus.addr == OFS_RESET_CONTROL_REGISTER) begin
            fl_r <= bus.wdata[RC_WATCHDOG_TIMEOUT_FLAG];
         end
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   AST_RST_QUIET: assert property (
      $fell(rst) |-> !wdt_reset && !wake && !running && rdata == 32'h0)
      else $error("outputs busy after reset");
   AST_WAKE_PULSE: assert property (wake |-> !wdt_reset ##1 !wake)
      else $error("wake not a lone pulse");
   AST_OFF_SILENT: assert property (
      !running [*3] |-> !wdt_reset && !wake && osc_enable == 3'h0)
      else $error("stopped watchdog active");
   AST_EN_OFF: assert property (!en_r[1] && !$past(en_r[1]) |-> !running)
      else $error("runs with enable off");
   AST_EN_ON: assert property (en_r == 2'b11 && $past(en_r) == 2'b11 |-> running)
      else $error("stopped with enable on");
   AST_SWEN_CLR: assert property (ev.device_reset && en_r == 2'b10 |-> ##2 !running)
      else $error("soft enable survives reset");
   AST_FLAG: assert property (
      bus.rd && bus.addr == OFS_RESET_CONTROL_REGISTER |=> rdata[RC_WATCHDOG_TIMEOUT_FLAG] == $past(fl))
      else $error("time-out flag wrong");
   AST_MUX_OFF: assert property (
      running && $past(running) && !mx_r && !$past(mx_r) |-> osc_enable == 3'b100)
      else $error("low-power source not requested");
   COV_RESET: cover property (wdt_reset);
   COV_WAKE: cover property (wake);
   COV_FAST: cover property (running && osc_enable == 3'b010);
endmodule : windowed_watchdog_timer_props

bind windowed_watchdog_timer windowed_watchdog_timer_props u_windowed_watchdog_timer_props (
   .clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .ev(ev), .osc_in(osc_in),
   .osc_enable(osc_enable), .wdt_reset(wdt_reset), .wake(wake), .running(running));
`default_nettype wire

// file: bench/windowed_watchdog_timer_tb.sv
`default_nettype none
module windowed_watchdog_timer_tb
   import wdt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst, wdt_reset, wake, running;
   logic [31:0] rdata, v;
   logic [1:0]  ph;
   bus_req_s    bus;
   ev_s         ev;
   osc_s        osc_in, osc_enable;
   int          error_cnt, compares, seed, n, e, r;
   int          opn [4] = '{96, 80, 64, 32};
   logic [31:0] mc [6] = '{32'h1e0, 32'h5e0, 32'h7e0, 32'h4e0, 32'h6e0, 32'h6c0};
   logic [2:0]  me [6] = '{3'h4, 3'h1, 3'h4, 3'h0, 3'h4, 3'h2};

   windowed_watchdog_timer u_windowed_watchdog_timer (.clk(clk), .rst(rst), .bus(bus),
      .rdata(rdata), .ev(ev), .osc_in(osc_in), .osc_enable(osc_enable),
      .wdt_reset(wdt_reset), .wake(wake), .running(running));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // source clocks: low-power rc every 4 cycles
   always @(posedge clk) begin
      ph <= ph + 2'h1;
      osc_in <= {ph[1], ph[0], 1'($random(seed))};
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      bus <= '0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge clk);
      bus <= '0;
      @(posedge clk);
      d = rdata;
   endtask : rd
   task automatic evp(input logic [6:0] m);
      ev <= m;
      @(posedge clk);
      ev <= '0;
      @(posedge clk);
   endtask : evp
   task automatic wt(output int c);
      c = 0;
      while (!(wdt_reset | wake) && c < 20000) begin
         @(posedge clk);
         c++;
      end
   endtask : wt
   task automatic conclude;
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : conclude

   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      $display("mismatch at %0t: timeout", $time);
      conclude();
   end

   initial begin
      seed = 95;
      error_cnt = 0;
      compares = 0;
      ph = 2'h0;
      bus = '0;
      ev = '0;
      osc_in = '0;
      rst = 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(OFS_CFG, v);
      chk(v, 32'h3bf);
      rd(OFS_RESET_CONTROL_REGISTER, v);
      chk(v, 32'h0);
      rd(4'hc, v);
      chk(v, 32'h0);
      // period from prescale and postscale
      for (int k = 0; k < 6; k++) begin
         r = (k == 0) ? 0 : (k == 1) ? 32'h13 : $random(seed);
         e = (128 << r[1:0]) * (r[4] ? 4 : 1);
         evp(7'h04);
         wr(OFS_CFG, 32'he0 | (r & 32'h13));
         wt(n);
         chk(n > e - 12 && n < e + 12 && wdt_reset, 1);
         repeat (20) @(posedge clk);
         rd(OFS_RESET_CONTROL_REGISTER, v);
         chk(v, 32'h10);
         wr(OFS_RESET_CONTROL_REGISTER, 32'h0);
      end
      evp(7'h04);
      wr(OFS_CFG, 32'he0);
      repeat (40) @(posedge clk);
      evp(7'h40);
      wt(n);
      chk(n > 110 && n < 140, 1);
      // clock switch restarts the count
      repeat (60) @(posedge clk);
      evp(7'h08);
      wt(n);
      chk(n > 110 && n < 140 && wdt_reset, 1);
      // window codes: early and in-window clear
      for (int k = 0; k < 4; k++) begin
         evp(7'h04);
         wr(OFS_CFG, 32'hc0 | (k << 11));
         repeat (opn[k] - 20) @(posedge clk);
         evp(7'h40);
         wt(n);
         chk(n < 4 && wdt_reset, 1);
         repeat (opn[k] + 12) @(posedge clk);
         evp(7'h40);
         wt(n);
         chk(n > 110 && n < 140 && wdt_reset, 1);
      end
      // sleep then idle
      for (int k = 0; k < 2; k++) begin
         evp(7'h04);
         wr(OFS_CFG, 32'he0);
         repeat (60) @(posedge clk);
         evp(7'h20 | 7'(k << 4));
         wt(n);
         chk(n > 110 && n < 140 && wake, 1);
         rd(OFS_RESET_CONTROL_REGISTER, v);
         chk(v, 32'h10 | (32'h8 >> k));
         wr(OFS_RESET_CONTROL_REGISTER, 32'h0);
      end
      wr(OFS_CFG, 32'h20);
      wr(OFS_RESET_CONTROL_REGISTER, 32'h20);
      chk(running, 1'b0);
      wr(OFS_CFG, 32'ha0);
      @(posedge clk);
      chk(running, 1'b1);
      evp(7'h04);
      @(posedge clk);
      chk(running, 1'b0);
      wr(OFS_CFG, 32'he0);
      @(posedge clk);
      chk(running, 1'b1);
      // source selection table
      for (int k = 0; k < 6; k++) begin
         wr(OFS_CFG, mc[k]);
         @(posedge clk);
         chk(osc_enable, me[k]);
      end
      conclude();
   end
endmodule : windowed_watchdog_timer_tb
`default_nettype wire
